// ==== verilog/fsgen_pkg.sv ====
package fsgen_pkg;

  // register byte addresses
  localparam logic [7:0] FSGEN_CTRL_ADDR = 8'h18;
  localparam logic [7:0] FSGEN_ASPAN_HI_ADDR = 8'h19;
  localparam logic [7:0] FSGEN_ASPAN_LO_ADDR = 8'h1a;
  localparam logic [7:0] FSGEN_DSPAN_HI_ADDR = 8'h1b;
  localparam logic [7:0] FSGEN_DSPAN_LO_ADDR = 8'h1c;
  localparam logic [7:0] FSGEN_LIMIT_HI_ADDR = 8'h1d;
  localparam logic [7:0] FSGEN_LIMIT_LO_ADDR = 8'h1e;

  // control register field positions
  localparam int FSGEN_SRC_MSB = 7;
  localparam int FSGEN_SRC_LSB = 4;
  localparam int FSGEN_ONESHOT_BIT = 3;
  localparam int FSGEN_IDLE_BIT = 2;
  localparam int FSGEN_SPLIT_BIT = 1;
  localparam int FSGEN_ENABLE_BIT = 0;

  // values after reset
  localparam logic [7:0] FSGEN_CTRL_RST = 8'h00;
  localparam logic [7:0] FSGEN_SPAN_RST = 8'h00;
  localparam logic [7:0] FSGEN_LIMIT_RST = 8'h00;
  localparam logic [7:0] FSGEN_RDATA_RST = 8'h00;
  localparam logic [23:0] FSGEN_CNT_RST = 24'h000000;
  localparam logic [15:0] FSGEN_FRAME_RST = 16'h0000;

  // frame numbering
  localparam logic [15:0] FSGEN_FRAME_FIRST = 16'h0001;
  localparam logic [15:0] FSGEN_FRAME_OFF = 16'h0000;

  // source select decode
  localparam logic [1:0] FSGEN_SRC_GRP_PORT = 2'h0;
  localparam logic [1:0] FSGEN_SRC_GRP_REF = 2'h1;

  typedef enum logic [1:0] {
    FSGEN_IDLE,
    FSGEN_RUN,
    FSGEN_SINGLE
  } fsgen_state_t;

endpackage : fsgen_pkg

// ==== verilog/fsgen_frame_sync_generator.sv ====
// Overview of operation
// RULE1: source 0000-0011 generates internally, timed by back-channel port 0-3 ticks.
// RULE2: source 01xx generates internally, timed by the 25MHz reference tick.
// RULE3: source 1000-1111 passes the level of gpio pin 0-7 straight out.
// RULE4: writing one to control bit 3 emits one pulse; bit reads zero.
// RULE5: software waits for a one-shot pulse to finish before asking again.
// RULE6: software keeps periodic enable low while using the one-shot pulse.
// RULE7: control bit 2 sets the starting and idle level of the pulse.
// RULE8: split select 0 times high and low phases by separate 16-bit counts.
// RULE9: split select 1 uses one 24-bit count for both phases.
// RULE10: control bit 0 turns periodic generation on when 1, off when 0.
// RULE11: each phase lasts programmed count plus one timebase cycle.
// RULE12: asserted count bits 15:8 at 0x19, bits 7:0 at 0x1a.
// RULE13: deasserted count bits 15:8 at 0x1b, bits 7:0 at 0x1c.
// RULE14: in raw mode a 16-bit frame number is given for each frame.
// RULE15: a zero frame limit disables numbering; the number stays 0.
// RULE16: nonzero limit: number counts 1 up to the limit, then back to 1.
// RULE17: frame limit bits 15:8 are held at 0x1d.
// RULE18: frame limit bits 7:0 are held at 0x1e.
// RULE19: periodic output starts at the idle level, then alternates phases.
//
// The strobed register port was decided locally.
`timescale 1ns/1ps
module fsgen_frame_sync_generator
  import fsgen_pkg::*;
#(
  parameter int NUM_RX_PORTS = 4,
  parameter int NUM_GPIO = 8
)(
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // register port
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWdata,
  input wire logic regWr,
  input wire logic regRd,
  output logic [7:0] regRdata,
  // timebase ticks, one cycle each
  input wire logic [NUM_RX_PORTS-1:0] bcFrameTick,
  input wire logic refTick25,
  // external sync sources
  input wire logic [NUM_GPIO-1:0] gpioIn,
  // frame numbering
  input wire logic rawMode,
  input wire logic frameBegin,
  output logic [15:0] frameNumber,
  // generated sync
  output logic framePulse
);

  if (NUM_RX_PORTS != 4 || NUM_GPIO != 8)
  begin : g_param_check
    $error("fsgen: source select serves exactly 4 ports and 8 pins");
  end

  logic [7:0] ctrl_q;
  logic [7:0] aspanHi_q;
  logic [7:0] aspanLo_q;
  logic [7:0] dspanHi_q;
  logic [7:0] dspanLo_q;
  logic [7:0] limitHi_q;
  logic [7:0] limitLo_q;
  logic [7:0] rdata_d;
  logic [7:0] rdata_q;
  logic [3:0] srcSel;
  logic idleLevel;
  logic splitSel;
  logic genOn;
  logic oneShotReq;
  logic tick;
  logic extMode;
  logic [23:0] highSpan;
  logic [23:0] lowSpan;
  logic [23:0] curSpan;
  logic [15:0] frameLimit;
  fsgen_state_t state_q;
  logic [23:0] cnt_q;
  logic level_q;
  logic pulse_q;
  logic [15:0] frameNum_q;

  function automatic logic regHit(input logic [7:0] a, input logic [7:0] o);
    regHit = (a == o);
  endfunction : regHit

  assign srcSel = ctrl_q[FSGEN_SRC_MSB:FSGEN_SRC_LSB];
  assign idleLevel = ctrl_q[FSGEN_IDLE_BIT];
  assign splitSel = ctrl_q[FSGEN_SPLIT_BIT];
  assign genOn = ctrl_q[FSGEN_ENABLE_BIT];
  assign extMode = srcSel[3];
  assign frameLimit = {limitHi_q, limitLo_q};
  // self-clearing bit: the write only fires a request, nothing is stored
  assign oneShotReq = regWr && regHit(regAddr, FSGEN_CTRL_ADDR)
    && regWdata[FSGEN_ONESHOT_BIT]; // see RULE4

  // register writes
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      ctrl_q <= FSGEN_CTRL_RST;
      aspanHi_q <= FSGEN_SPAN_RST;
      aspanLo_q <= FSGEN_SPAN_RST;
      dspanHi_q <= FSGEN_SPAN_RST;
      dspanLo_q <= FSGEN_SPAN_RST;
      limitHi_q <= FSGEN_LIMIT_RST;
      limitLo_q <= FSGEN_LIMIT_RST;
    end
    else if (regWr)
    begin
      case (regAddr)
        FSGEN_CTRL_ADDR:
          ctrl_q <= regWdata & ~(8'h01 << FSGEN_ONESHOT_BIT); // see RULE4
        FSGEN_ASPAN_HI_ADDR: aspanHi_q <= regWdata; // see RULE12
        FSGEN_ASPAN_LO_ADDR: aspanLo_q <= regWdata; // see RULE12
        FSGEN_DSPAN_HI_ADDR: dspanHi_q <= regWdata; // see RULE13
        FSGEN_DSPAN_LO_ADDR: dspanLo_q <= regWdata; // see RULE13
        FSGEN_LIMIT_HI_ADDR: limitHi_q <= regWdata; // see RULE17
        FSGEN_LIMIT_LO_ADDR: limitLo_q <= regWdata; // see RULE18
        default: ;
      endcase
    end
  end

  // read mux, unmapped addresses read zero
  always_comb
  begin
    rdata_d = 8'h00;
    case (regAddr)
      FSGEN_CTRL_ADDR: rdata_d = ctrl_q;
      FSGEN_ASPAN_HI_ADDR: rdata_d = aspanHi_q;
      FSGEN_ASPAN_LO_ADDR: rdata_d = aspanLo_q;
      FSGEN_DSPAN_HI_ADDR: rdata_d = dspanHi_q;
      FSGEN_DSPAN_LO_ADDR: rdata_d = dspanLo_q;
      FSGEN_LIMIT_HI_ADDR: rdata_d = limitHi_q;
      FSGEN_LIMIT_LO_ADDR: rdata_d = limitLo_q;
      default: rdata_d = 8'h00;
    endcase
  end

  // data only valid the cycle after the strobe
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      rdata_q <= FSGEN_RDATA_RST;
    else if (regRd)
      rdata_q <= rdata_d;
    else
      rdata_q <= FSGEN_RDATA_RST;
  end
  assign regRdata = rdata_q;

  // timebase selection
  always_comb
  begin
    tick = 1'b0;
    case (srcSel[3:2])
      FSGEN_SRC_GRP_PORT: tick = bcFrameTick[srcSel[1:0]]; // see RULE1
      FSGEN_SRC_GRP_REF: tick = refTick25; // see RULE2
      default: tick = 1'b0;
    endcase
  end

  // 50/50 joins three bytes; the upper asserted byte is unused there
  assign highSpan = splitSel ? {aspanLo_q, dspanHi_q, dspanLo_q}
    : {8'h00, aspanHi_q, aspanLo_q}; // see RULE8, see RULE9
  assign lowSpan = splitSel ? {aspanLo_q, dspanHi_q, dspanLo_q}
    : {8'h00, dspanHi_q, dspanLo_q}; // see RULE8, see RULE9
  assign curSpan = level_q ? highSpan : lowSpan;

  // generator state machine
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      state_q <= FSGEN_IDLE;
      cnt_q <= FSGEN_CNT_RST;
      level_q <= 1'b0;
    end
    else
    begin
      case (state_q)
        FSGEN_IDLE:
        begin
          cnt_q <= FSGEN_CNT_RST;
          level_q <= idleLevel; // see RULE7
          if (extMode)
            state_q <= FSGEN_IDLE;
          else if (genOn)
            state_q <= FSGEN_RUN; // see RULE19
          else if (oneShotReq)
          begin
            // one pulse is the level opposite to idle
            state_q <= FSGEN_SINGLE; // see RULE4
            level_q <= ~idleLevel;
          end
        end
        FSGEN_RUN:
        begin
          if (!genOn || extMode)
          begin
            state_q <= FSGEN_IDLE; // see RULE10
            level_q <= idleLevel;
            cnt_q <= FSGEN_CNT_RST;
          end
          else if (tick)
          begin
            if (cnt_q >= curSpan)
            begin
              level_q <= ~level_q; // see RULE11, see RULE19
              cnt_q <= FSGEN_CNT_RST;
            end
            else
              cnt_q <= cnt_q + 24'h000001;
          end
        end
        FSGEN_SINGLE:
        begin
          // requests here are dropped, software spaces them
          if (extMode)
          begin
            state_q <= FSGEN_IDLE; // see RULE5
            level_q <= idleLevel;
            cnt_q <= FSGEN_CNT_RST;
          end
          else if (tick)
          begin
            if (cnt_q >= curSpan)
            begin
              state_q <= FSGEN_IDLE; // see RULE11
              level_q <= idleLevel;
              cnt_q <= FSGEN_CNT_RST;
            end
            else
              cnt_q <= cnt_q + 24'h000001;
          end
        end
        default:
        begin
          state_q <= FSGEN_IDLE;
          cnt_q <= FSGEN_CNT_RST;
          level_q <= idleLevel;
        end
      endcase
    end
  end

  // output register, external pins bypass the generator
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      pulse_q <= 1'b0;
    else if (extMode)
      pulse_q <= gpioIn[srcSel[2:0]]; // see RULE3
    else
      pulse_q <= level_q;
  end
  assign framePulse = pulse_q;

  // frame number for start and end packets of the current frame
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
      frameNum_q <= FSGEN_FRAME_RST;
    else if (frameLimit == FSGEN_FRAME_OFF)
      frameNum_q <= FSGEN_FRAME_OFF; // see RULE15
    else if (rawMode && frameBegin)
    begin
      // a lowered limit below the count also wraps at once
      if (frameNum_q >= frameLimit)
        frameNum_q <= FSGEN_FRAME_FIRST; // see RULE16
      else
        frameNum_q <= frameNum_q + 16'h0001; // see RULE14, see RULE16
    end
  end
  assign frameNumber = frameNum_q;

  oneshot_reads_zero_a: assert property ( // see RULE4
    @(posedge clk_sys) disable iff (sys_rst)
    regRd && regHit(regAddr, FSGEN_CTRL_ADDR) |=> !regRdata[3])
    else $error("one-shot bit read back as one");

  port_tick_sel_a: assert property ( // see RULE1
    @(posedge clk_sys) disable iff (sys_rst)
    (srcSel[3:2] == 2'h0) |-> (tick == bcFrameTick[srcSel[1:0]]))
    else $error("port timebase tick not selected");

  ref_tick_sel_a: assert property ( // see RULE2
    @(posedge clk_sys) disable iff (sys_rst)
    (srcSel[3:2] == 2'h1) |-> (tick == refTick25))
    else $error("reference tick not selected");

  ext_passthru_a: assert property ( // see RULE3
    @(posedge clk_sys) disable iff (sys_rst)
    extMode ##1 extMode && $stable(srcSel)
      |-> framePulse == $past(gpioIn[srcSel[2:0]]))
    else $error("external pin not passed to the output");

  idle_level_out_a: assert property ( // see RULE7
    @(posedge clk_sys) disable iff (sys_rst)
    (state_q == FSGEN_IDLE) && !extMode && !genOn && !oneShotReq
      && $stable(idleLevel) ##1 (state_q == FSGEN_IDLE) && !extMode
      |=> framePulse == $past(idleLevel, 2))
    else $error("idle output differs from idle level");

  oneshot_start_a: assert property ( // see RULE4
    @(posedge clk_sys) disable iff (sys_rst)
    (state_q == FSGEN_IDLE) && !extMode && !genOn && oneShotReq
      |=> (state_q == FSGEN_SINGLE) ##1 framePulse == !$past(idleLevel, 2))
    else $error("one-shot request gave no pulse");

  phase_toggle_a: assert property ( // see RULE11
    @(posedge clk_sys) disable iff (sys_rst)
    (state_q == FSGEN_RUN) && genOn && !extMode && tick
      && cnt_q == curSpan |=> level_q != $past(level_q) && cnt_q == 24'h0)
    else $error("phase did not end after count plus one ticks");

  phase_hold_a: assert property ( // see RULE11
    @(posedge clk_sys) disable iff (sys_rst)
    (state_q == FSGEN_RUN) && genOn && !extMode && cnt_q < curSpan
      |=> level_q == $past(level_q))
    else $error("phase ended early");

  split_span_a: assert property ( // see RULE9
    @(posedge clk_sys) disable iff (sys_rst)
    splitSel |-> highSpan == lowSpan
      && highSpan[23:16] == aspanLo_q && highSpan[7:0] == dspanLo_q)
    else $error("50/50 span not assembled from three bytes");

  hilo_span_a: assert property ( // see RULE8
    @(posedge clk_sys) disable iff (sys_rst)
    !splitSel |-> highSpan == {8'h00, aspanHi_q, aspanLo_q}
      && lowSpan == {8'h00, dspanHi_q, dspanLo_q})
    else $error("high/low spans not independent");

  gen_off_a: assert property ( // see RULE10
    @(posedge clk_sys) disable iff (sys_rst)
    (state_q == FSGEN_RUN) && !genOn |=> state_q == FSGEN_IDLE)
    else $error("periodic generation kept running when off");

  gen_on_a: assert property ( // see RULE19
    @(posedge clk_sys) disable iff (sys_rst)
    (state_q == FSGEN_IDLE) && genOn && !extMode
      |=> state_q == FSGEN_RUN && level_q == $past(idleLevel))
    else $error("periodic start not at idle level");

  frame_off_a: assert property ( // see RULE15
    @(posedge clk_sys) disable iff (sys_rst)
    frameLimit == 16'h0 |=> frameNumber == 16'h0)
    else $error("frame number nonzero with zero limit");

  frame_wrap_a: assert property ( // see RULE16
    @(posedge clk_sys) disable iff (sys_rst)
    frameLimit != 16'h0 && rawMode && frameBegin && frameNumber >= frameLimit
      |=> frameNumber == 16'h1)
    else $error("frame number did not wrap to one");

  frame_step_a: assert property ( // see RULE14
    @(posedge clk_sys) disable iff (sys_rst)
    frameLimit != 16'h0 && rawMode && frameBegin && frameNumber < frameLimit
      |=> frameNumber == $past(frameNumber) + 16'h1)
    else $error("frame number did not advance by one");

  limit_readback_a: assert property ( // see RULE18
    @(posedge clk_sys) disable iff (sys_rst)
    regWr && regAddr == 8'h1e ##1 regRd && regAddr == 8'h1e
      |=> regRdata == $past(regWdata, 2))
    else $error("limit low byte did not read back");

endmodule : fsgen_frame_sync_generator

// ==== tb/fsgen_far_side_model.sv ====
`timescale 1ns/1ps
module fsgen_far_side_model (
  // clock and reset
  input wire logic clk_sys,
  input wire logic sys_rst,
  // timebase ticks toward the generator
  output logic [3:0] bcFrameTick,
  output logic refTick25,
  // sync as seen by the remote serializers
  input wire logic framePulse,
  output int lastHigh,
  output int lastLow,
  output int riseCount
);
  int tickCnt [5];
  int runLen;
  logic prevLevel;
  // every source ticks at its own rate: a wrong select shows as a wrong length
  always_ff @(posedge clk_sys)
  begin
    for (int p = 0; p < 5; p++)
    begin
      if (sys_rst || tickCnt[p] == ((p < 4) ? p : 5))
        tickCnt[p] <= 0;
      else
        tickCnt[p] <= tickCnt[p] + 1;
    end
  end
  always_comb
  begin
    for (int p = 0; p < 4; p++)
      bcFrameTick[p] = (tickCnt[p] == 0);
    refTick25 = (tickCnt[4] == 0);
  end
  // run lengths in system cycles, recorded when a phase ends
  always_ff @(posedge clk_sys)
  begin
    if (sys_rst)
    begin
      runLen <= 0;
      lastHigh <= 0;
      lastLow <= 0;
      riseCount <= 0;
    end
    else if (framePulse == prevLevel)
      runLen <= runLen + 1;
    else
    begin
      if (prevLevel)
        lastHigh <= runLen;
      else
        lastLow <= runLen;
      runLen <= 1;
      if (framePulse)
        riseCount <= riseCount + 1;
    end
    prevLevel <= sys_rst ? 1'b0 : framePulse;
  end
endmodule : fsgen_far_side_model

// ==== tb/tb_frame_sync_generator.sv ====
`timescale 1ns/1ps
module tb_frame_sync_generator;
  import fsgen_pkg::*;
  logic clk_sys, sys_rst, regWr, regRd, rawMode, frameBegin, refTick25;
  logic [7:0] regAddr, regWdata, regRdata, gpioIn;
  logic [3:0] bcFrameTick;
  logic [15:0] frameNumber;
  logic framePulse;
  int lastHigh, lastLow, riseCount, errCount, nTests, r0, p;
  logic [7:0] a;
  logic [3:0] srcs [6] = '{4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h7};
  fsgen_frame_sync_generator u_dut (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr), .regRd(regRd),
    .regRdata(regRdata), .bcFrameTick(bcFrameTick), .refTick25(refTick25),
    .gpioIn(gpioIn), .rawMode(rawMode), .frameBegin(frameBegin),
    .frameNumber(frameNumber), .framePulse(framePulse));
  fsgen_far_side_model u_far (.clk_sys(clk_sys), .sys_rst(sys_rst),
    .bcFrameTick(bcFrameTick), .refTick25(refTick25),
    .framePulse(framePulse), .lastHigh(lastHigh), .lastLow(lastLow),
    .riseCount(riseCount));
  always #50 clk_sys = ~clk_sys;
  task giveVerdict;
    if (errCount == 0 && nTests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask : giveVerdict
  task check(input logic [23:0] seen, input logic [23:0] exp);
    nTests++;
    if (seen !== exp)
    begin
      errCount++;
      $display("unexpected at %0t: saw %h, wanted %h", $time, seen, exp);
    end
  endtask : check
  task wr(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
  endtask : wr
  task rd(input logic [7:0] ad, input logic [7:0] exp);
    @(posedge clk_sys);
    regRd <= 1'b1;
    regAddr <= ad;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check(regRdata, exp);
  endtask : rd
  // write then read back with no idle cycle between the strobes
  task wrRd(input logic [7:0] ad, input logic [7:0] d);
    @(posedge clk_sys);
    regWr <= 1'b1;
    regAddr <= ad;
    regWdata <= d;
    @(posedge clk_sys);
    regWr <= 1'b0;
    regRd <= 1'b1;
    @(posedge clk_sys);
    regRd <= 1'b0;
    #1;
    check(regRdata, d);
  endtask : wrRd
  // software programs each span as length minus one
  task setSpans(input logic [15:0] hi, input logic [15:0] lo);
    wr(FSGEN_ASPAN_HI_ADDR, hi[15:8]);
    wr(FSGEN_ASPAN_LO_ADDR, hi[7:0]);
    wr(FSGEN_DSPAN_HI_ADDR, lo[15:8]);
    wr(FSGEN_DSPAN_LO_ADDR, lo[7:0]);
  endtask : setSpans
  task frame;
    @(posedge clk_sys);
    frameBegin <= 1'b1;
    @(posedge clk_sys);
    frameBegin <= 1'b0;
    #1;
  endtask : frame
  task waitCyc(input int n);
    repeat (n) @(posedge clk_sys);
    #1;
  endtask : waitCyc
  initial
  begin
    #2000000;
    errCount++;
    giveVerdict();
  end
  initial
  begin
    clk_sys = 0;
    sys_rst = 1;
    regAddr = 0;
    regWdata = 0;
    regWr = 0;
    regRd = 0;
    gpioIn = 0;
    rawMode = 0;
    frameBegin = 0;
    errCount = 0;
    nTests = 0;
    repeat (4) @(posedge clk_sys);
    sys_rst <= 1'b0;
    for (a = 8'h18; a <= 8'h1e; a++)
      rd(a, 8'h00);
    wr(8'h20, 8'h5a);
    rd(8'h20, 8'h00);
    for (a = 8'h19; a <= 8'h1e; a++)
      wrRd(a, a ^ 8'ha5);
    setSpans(16'h0001, 16'h0002);
    for (int i = 0; i < 6; i++)
    begin
      p = (srcs[i] < 4) ? srcs[i] + 1 : 6;
      wr(FSGEN_CTRL_ADDR, {srcs[i], 4'h1});
      waitCyc(1);
      check(framePulse, 1'b0);
      waitCyc(120);
      check(lastHigh, 2 * p);
      check(lastLow, 3 * p);
      wr(FSGEN_CTRL_ADDR, 8'h00);
    end
    waitCyc(40);
    r0 = riseCount;
    waitCyc(40);
    check(riseCount, r0);
    wr(FSGEN_CTRL_ADDR, 8'h04);
    waitCyc(3);
    check(framePulse, 1'b1);
    wr(FSGEN_CTRL_ADDR, 8'h05);
    waitCyc(40);
    check(lastHigh, 2);
    check(lastLow, 3);
    // upper asserted byte must not reach the 24-bit half period
    setSpans(16'h0500, 16'h0003);
    wr(FSGEN_CTRL_ADDR, 8'h03);
    waitCyc(60);
    check(lastHigh, 4);
    check(lastLow, 4);
    wr(FSGEN_CTRL_ADDR, 8'h00);
    for (int s = 0; s <= 2; s += 2)
    begin
      setSpans(s[15:0], 16'h0000);
      waitCyc(10);
      r0 = riseCount;
      wr(FSGEN_CTRL_ADDR, 8'h08);
      rd(FSGEN_CTRL_ADDR, 8'h00);
      waitCyc(20);
      check(riseCount, r0 + 1);
      check(lastHigh, s + 1);
    end
    for (int g = 0; g < 8; g++)
    begin
      wr(FSGEN_CTRL_ADDR, {1'b1, g[2:0], 4'h0});
      gpioIn <= 8'h01 << g;
      waitCyc(2);
      check(framePulse, 1'b1);
      @(posedge clk_sys);
      gpioIn <= ~(8'h01 << g);
      waitCyc(2);
      check(framePulse, 1'b0);
    end
    wr(FSGEN_LIMIT_HI_ADDR, 8'h00);
    wr(FSGEN_LIMIT_LO_ADDR, 8'h02);
    rawMode <= 1'b1;
    for (int f = 0; f < 3; f++)
    begin
      frame();
      check(frameNumber, (f == 1) ? 2 : 1);
    end
    @(posedge clk_sys);
    rawMode <= 1'b0;
    frame();
    check(frameNumber, 16'h0001);
    @(posedge clk_sys);
    rawMode <= 1'b1;
    wr(FSGEN_LIMIT_LO_ADDR, 8'h00);
    frame();
    check(frameNumber, 16'h0000);
    wr(FSGEN_LIMIT_HI_ADDR, 8'h01);
    frame();
    check(frameNumber, 16'h0001);
    giveVerdict();
  end
endmodule : tb_frame_sync_generator
